// ---- verilog/vpi_irq_enable.sv ----
// Video port interrupt enable and event flag block with an APB slave.
// Assumes event pulses synchronous to pclk from the port's detectors.
//
// Summary of operation
// - Bit 17 gates channel B capture overrun.
// - Bit 16 gates general purpose I/O event.
// - Bit 14 gates display done unacknowledged.
// - Bit 13 gates display complete event.
// - Bit 12 gates display underrun event.
// - Bit 11 gates time clock tick.
// - Bit 10 gates time clock compare.
// - Bits 15, 9, 8 read zero, ignore writes.
// - Bit 7 gates channel A long field.
// - Bit 6 gates channel A short field.
// - Bit 5 gates channel A field 2 vertical.
// - Bit 4 gates channel A field 1 vertical.
// - Bit 3 gates channel A sync error.
// - Bit 2 gates channel A capture complete.
// - Bit 1 gates channel A capture overrun.
// - Bit 0 global enable, required for any interrupt.
// - Flag interrupts only while its enable set.
// - Writing one clears a flag; zero keeps.
`timescale 1ns/10ps
`default_nettype none

module vpi_irq_enable (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata_q,
  output logic pready_q,
  output logic pslverr_q,
  // Event pulses from the port detectors, one per flag position.
  input wire logic [31:0] event_i,
  // Interrupt to the host processor.
  output logic irq_q
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] en_q; // Interrupt enable word.
  logic [31:0] en_d; // Next enable word.
  logic [31:0] flag_q; // Sticky event flags.
  logic [31:0] hit; // Flags that have their own enable set.
  logic [31:0] wmask; // Bits touched by the byte strobes.
  logic access; // Completing access phase.
  logic setup; // Setup phase of a new transfer.
  logic sel_en; // Address selects the enable word.
  logic sel_flag; // Address selects the flag word.
  logic en_wr; // Enable word written at this edge.
  logic flag_wr; // Flag word written at this edge.
  logic [31:0] clr; // Per-bit clear request.
  logic irq_d; // Next interrupt level.

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // The slave answers one cycle after setup, so a write takes effect
  // at the edge that ends the first access cycle.
  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign sel_en = (paddr == vpi_pkg::OFS_ENABLE);
  assign sel_flag = (paddr == vpi_pkg::OFS_FLAGS);
  assign en_wr = access && pwrite && sel_en;
  assign flag_wr = access && pwrite && sel_flag;

  // Byte strobes widen to a bit mask with one loop.
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_strb
      assign wmask[gb*8 +: 8] = {8{pstrb[gb]}};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Enable word
  // ----------------------------------------------------------------
  // Only the documented enable bits accept data; reserved and
  // out-of-scope channel B bits stay zero whatever is written.
  always_comb begin
    en_d = en_q;
    if (en_wr) begin
      en_d = ((en_q & ~wmask) | (pwdata & wmask)) & vpi_pkg::EN_MASK;
    end
  end

  // The enable word resets to all disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= vpi_pkg::EN_RESET;
    end else begin
      en_q <= en_d;
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // A one in a written byte lane clears that flag; zeros keep it.
  assign clr = flag_wr ? (pwdata & wmask) : 32'h0000_0000;

  // One cell per position; unimplemented positions hold zero so the
  // word reads back clean.
  genvar gf;
  generate
    for (gf = 0; gf < 32; gf++) begin : g_flag
      vpi_flag_cell #(
        .IMPL(vpi_pkg::FLAG_MASK[gf])
      ) u_cell (
        .pclk(pclk),
        .presetn(presetn),
        .event_i(event_i[gf]),
        .clear_i(clr[gf]),
        .flag_q(flag_q[gf])
      );
    end
  endgenerate

  // A flag only falls where a one was written to it; a stray clear
  // would lose an event that software has not yet seen.
  flag_sticky_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (($past(flag_q) & ~$past(clr)) & ~flag_q) == 32'h0000_0000)
    else $error("Flag fell without a clear.");

  // ----------------------------------------------------------------
  // Interrupt gating
  // ----------------------------------------------------------------
  // Each flag reaches the interrupt only through its own enable bit.
  always_comb begin
    hit = 32'h0000_0000;
    hit[vpi_pkg::B_CHB_OVR] = flag_q[vpi_pkg::B_CHB_OVR] & en_q[vpi_pkg::B_CHB_OVR];
    hit[vpi_pkg::B_GPIO] = flag_q[vpi_pkg::B_GPIO] & en_q[vpi_pkg::B_GPIO];
    hit[vpi_pkg::B_DISP_UNACK] =
      flag_q[vpi_pkg::B_DISP_UNACK] & en_q[vpi_pkg::B_DISP_UNACK];
    hit[vpi_pkg::B_DISP_DONE] = flag_q[vpi_pkg::B_DISP_DONE] & en_q[vpi_pkg::B_DISP_DONE];
    hit[vpi_pkg::B_DISP_UNDER] =
      flag_q[vpi_pkg::B_DISP_UNDER] & en_q[vpi_pkg::B_DISP_UNDER];
    hit[vpi_pkg::B_TC_TICK] = flag_q[vpi_pkg::B_TC_TICK] & en_q[vpi_pkg::B_TC_TICK];
    hit[vpi_pkg::B_TC_COMPARE] =
      flag_q[vpi_pkg::B_TC_COMPARE] & en_q[vpi_pkg::B_TC_COMPARE];
    hit[vpi_pkg::B_CHA_LONG] = flag_q[vpi_pkg::B_CHA_LONG] & en_q[vpi_pkg::B_CHA_LONG];
    hit[vpi_pkg::B_CHA_SHORT] = flag_q[vpi_pkg::B_CHA_SHORT] & en_q[vpi_pkg::B_CHA_SHORT];
    hit[vpi_pkg::B_CHA_F2V] = flag_q[vpi_pkg::B_CHA_F2V] & en_q[vpi_pkg::B_CHA_F2V];
    hit[vpi_pkg::B_CHA_F1V] = flag_q[vpi_pkg::B_CHA_F1V] & en_q[vpi_pkg::B_CHA_F1V];
    hit[vpi_pkg::B_CHA_SYNC] = flag_q[vpi_pkg::B_CHA_SYNC] & en_q[vpi_pkg::B_CHA_SYNC];
    hit[vpi_pkg::B_CHA_DONE] = flag_q[vpi_pkg::B_CHA_DONE] & en_q[vpi_pkg::B_CHA_DONE];
    hit[vpi_pkg::B_CHA_OVR] = flag_q[vpi_pkg::B_CHA_OVR] & en_q[vpi_pkg::B_CHA_OVR];
  end

  // The global bit is the last gate; nothing leaves without it.
  assign irq_d = en_q[vpi_pkg::B_GLOBAL] && (|hit);

  // Each source on its own: with only its flag up, the output one edge
  // later follows that source's enable and the global bit, nothing else.
  chb_overrun_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_CHB_OVR))
      |=> irq_q == $past(en_q[vpi_pkg::B_CHB_OVR] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Channel B overrun flag not gated by its enable.");

  gpio_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_GPIO))
      |=> irq_q == $past(en_q[vpi_pkg::B_GPIO] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("General purpose flag not gated by its enable.");

  unacked_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_DISP_UNACK))
      |=> irq_q == $past(en_q[vpi_pkg::B_DISP_UNACK] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Display unacknowledged flag not gated by its enable.");

  disp_done_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_DISP_DONE))
      |=> irq_q == $past(en_q[vpi_pkg::B_DISP_DONE] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Display complete flag not gated by its enable.");

  underrun_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_DISP_UNDER))
      |=> irq_q == $past(en_q[vpi_pkg::B_DISP_UNDER] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Display underrun flag not gated by its enable.");

  tick_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_TC_TICK))
      |=> irq_q == $past(en_q[vpi_pkg::B_TC_TICK] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Time clock tick flag not gated by its enable.");

  compare_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_TC_COMPARE))
      |=> irq_q == $past(en_q[vpi_pkg::B_TC_COMPARE] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Time clock compare flag not gated by its enable.");

  long_field_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_CHA_LONG))
      |=> irq_q == $past(en_q[vpi_pkg::B_CHA_LONG] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Long field flag not gated by its enable.");

  short_field_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_CHA_SHORT))
      |=> irq_q == $past(en_q[vpi_pkg::B_CHA_SHORT] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Short field flag not gated by its enable.");

  field2_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_CHA_F2V))
      |=> irq_q == $past(en_q[vpi_pkg::B_CHA_F2V] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Field 2 vertical flag not gated by its enable.");

  field1_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_CHA_F1V))
      |=> irq_q == $past(en_q[vpi_pkg::B_CHA_F1V] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Field 1 vertical flag not gated by its enable.");

  sync_error_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_CHA_SYNC))
      |=> irq_q == $past(en_q[vpi_pkg::B_CHA_SYNC] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Sync error flag not gated by its enable.");

  capture_done_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_CHA_DONE))
      |=> irq_q == $past(en_q[vpi_pkg::B_CHA_DONE] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Capture complete flag not gated by its enable.");

  cha_overrun_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_q == (32'h1 << vpi_pkg::B_CHA_OVR))
      |=> irq_q == $past(en_q[vpi_pkg::B_CHA_OVR] && en_q[vpi_pkg::B_GLOBAL]))
    else $error("Channel A overrun flag not gated by its enable.");

  // The output is registered, so it trails the flags by one edge;
  // the host sees a clean level with no decode glitches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Ready rises for exactly the first access cycle of each transfer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= setup;
    end
  end

  // Unmapped addresses answer with an error and change nothing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !(sel_en || sel_flag);
    end else begin
      pslverr_q <= 1'b0;
    end
  end

  // Read data is captured in setup; reserved bits are already zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite && sel_en) begin
      prdata_q <= en_q;
    end else if (setup && !pwrite && sel_flag) begin
      prdata_q <= flag_q;
    end else begin
      prdata_q <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  reserved_en_zero_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (en_q & ~vpi_pkg::EN_MASK) == 32'h0000_0000)
    else $error("Reserved enable bit is set.");

  enable_write_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (en_wr && pstrb == 4'hF) |=> (en_q == ($past(pwdata) & vpi_pkg::EN_MASK)))
    else $error("Enable word did not take the written value.");

  global_gate_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      !en_q[vpi_pkg::B_GLOBAL] |=> !irq_q)
    else $error("Interrupt raised with global enable clear.");

  irq_cause_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq_q == $past(en_q[0] && ((flag_q & en_q & vpi_pkg::FLAG_MASK) != 32'h0)))
    else $error("Interrupt level does not match enabled flags.");

  flag_clear_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (flag_wr && pstrb == 4'hF && event_i == 32'h0)
      |=> flag_q == ($past(flag_q) & ~$past(pwdata)))
    else $error("Flag word did not clear as written.");

  set_wins_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (($past(event_i) & vpi_pkg::FLAG_MASK) & ~flag_q) == 32'h0)
    else $error("Event lost against a clear.");

  ready_timing_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready_q ##1 !pready_q)
    else $error("Ready not a single cycle after setup.");

  read_enable_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel_en) |=> (prdata_q == $past(en_q)) && !pslverr_q)
    else $error("Enable word read back wrong.");

  slverr_decode_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pslverr_q == !$past(sel_en || sel_flag))
    else $error("Error answer does not match the address decode.");

  read_flags_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && sel_flag) |=> prdata_q == $past(flag_q))
    else $error("Flag word read back wrong.");

  // Read data stays zero outside the access cycle, so a host that
  // samples late sees nothing stale.
  idle_rdata_a:
    assert property (@(posedge pclk) disable iff (!presetn)
      !pready_q |-> prdata_q == 32'h0000_0000)
    else $error("Read data not zero outside an access.");

endmodule // vpi_irq_enable

`default_nettype wire

// ---- verilog/vpi_pkg.sv ----
// Constants shared by the video port interrupt enable block.
// Assumes a 32-bit APB register bus and a 100 MHz peripheral clock.
package vpi_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Byte offset of the interrupt enable word.
  localparam logic [11:0] OFS_ENABLE = 12'h000;
  // Byte offset of the write-one-to-clear event flag word.
  localparam logic [11:0] OFS_FLAGS = 12'h004;

  // ----------------------------------------------------------------
  // Field positions, shared by the enable word and the flag word
  // ----------------------------------------------------------------
  localparam int B_GLOBAL = 0;
  localparam int B_CHA_OVR = 1;
  localparam int B_CHA_DONE = 2;
  localparam int B_CHA_SYNC = 3;
  localparam int B_CHA_F1V = 4;
  localparam int B_CHA_F2V = 5;
  localparam int B_CHA_SHORT = 6;
  localparam int B_CHA_LONG = 7;
  localparam int B_TC_COMPARE = 10;
  localparam int B_TC_TICK = 11;
  localparam int B_DISP_UNDER = 12;
  localparam int B_DISP_DONE = 13;
  localparam int B_DISP_UNACK = 14;
  localparam int B_GPIO = 16;
  localparam int B_CHB_OVR = 17;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  // Writable bits of the enable word; everything else reads zero.
  localparam logic [31:0] EN_MASK = 32'h0003_7CFF;
  // Implemented event flags; bit 0 has no event behind it.
  localparam logic [31:0] FLAG_MASK = 32'h0003_7CFE;
  // Both words come out of reset with everything disabled and clear.
  localparam logic [31:0] EN_RESET = 32'h0000_0000;
  localparam logic [31:0] FLAG_RESET = 32'h0000_0000;

endpackage : vpi_pkg

// ---- verilog/vpi_flag_cell.sv ----
// One sticky event flag with write-one-to-clear and set priority.
// Assumes the event is a pulse synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none

module vpi_flag_cell #(
  parameter logic IMPL = 1'b1
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Event and software clear.
  input wire logic event_i,
  input wire logic clear_i,
  // Flag state.
  output logic flag_q
);

  // ----------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------
  logic flag_d; // Next value of the flag.

  // An event in the same cycle as a clear keeps the flag set, so a
  // late event is never swallowed by a software clear.
  always_comb begin
    flag_d = flag_q;
    if (clear_i) begin
      flag_d = 1'b0;
    end
    if (event_i) begin
      flag_d = 1'b1;
    end
    if (!IMPL) begin
      flag_d = 1'b0;
    end
  end

  // The flag resets clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule // vpi_flag_cell

`default_nettype wire

// ---- tb/vpi_event_model.sv ----
// Model of the port's event detectors that feed the interrupt block.
// Assumes the bench raises fire_req right after a rising pclk edge.
`timescale 1ns/10ps
`default_nettype none

module vpi_event_model (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bench request, one bit per event position.
  input wire logic [31:0] fire_req,
  // Event pulses toward the block.
  output logic [31:0] event_o
);
  // ----------------------------------------------------------------
  // Pulse shaping
  // ----------------------------------------------------------------
  // Each request cycle becomes one registered pulse cycle.
  // The real detectors launch from a flop, so the pulse trails the
  // request by one edge, as it would in the port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_o <= 32'h0000_0000;
    end else begin
      event_o <= fire_req;
    end
  end
endmodule // vpi_event_model

`default_nettype wire

// ---- tb/vpi_irq_enable_test.sv ----
// Self-checking bench for the video port interrupt enable block.
// Assumes the APB slave answers one cycle after setup, as handed over.
`timescale 1ns/10ps
`default_nettype none

module vpi_irq_enable_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready_q, pslverr_q, irq_q, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, event_w, fire_req, rd;
  logic [3:0] pstrb;
  int num_errors, total_checks;
  // Event positions that carry a real enable bit, global bit excluded.
  localparam logic [31:0] EV_BITS = 32'h0003_7CFE;
  localparam logic [11:0] EN = vpi_pkg::OFS_ENABLE;
  localparam logic [11:0] FL = vpi_pkg::OFS_FLAGS;

  vpi_irq_enable dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .event_i(event_w), .irq_q(irq_q));
  vpi_event_model evm (.pclk(pclk), .presetn(presetn), .fire_req(fire_req),
    .event_o(event_w));

  // 100 MHz clock.
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Case equality keeps an unknown from passing as a match.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; the leading edge keeps back-to-back calls legal.
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    // Waits as long as the slave asks; only the watchdog ends a hang.
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Fires events and waits long enough for flag and interrupt to settle.
  task automatic fire(input logic [31:0] mask);
    @(posedge pclk);
    fire_req <= mask;
    @(posedge pclk);
    fire_req <= 32'h0000_0000;
    repeat (3) @(posedge pclk);
  endtask

  // Irq is registered behind the flag and enable words.
  task automatic irq_is(input string name, input logic exp);
    repeat (2) @(posedge pclk);
    check(name, {31'h0, irq_q}, {31'h0, exp});
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    fire_req = 32'h0000_0000;
    num_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, EN, 32'h0);
    check("enable_reset", rd, 32'h0000_0000);
    apb(1'b0, FL, 32'h0);
    check("flags_reset", rd, 32'h0000_0000);
    irq_is("irq_reset", 1'b0);
    // Reserved bits read zero whatever is written.
    apb(1'b1, EN, 32'hFFFF_FFFF);
    apb(1'b0, EN, 32'h0);
    check("enable_rw", rd, 32'h0003_7CFF);
    // A cleared byte strobe leaves its lane of the enable word alone.
    pstrb <= 4'h2;
    apb(1'b1, EN, 32'h0000_0000);
    pstrb <= 4'hF;
    apb(1'b0, EN, 32'h0);
    check("enable_lane", rd, 32'h0003_00FF);
    check("mapped_ok", {31'h0, err}, 32'h0);
    // Unmapped addresses answer with an error and write nothing.
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_rdata", rd, 32'h0000_0000);
    apb(1'b1, 12'h008, 32'hFFFF_FFFF);
    check("unmapped_werr", {31'h0, err}, 32'h1);
    apb(1'b0, EN, 32'h0);
    check("unmapped_nowrite", rd, 32'h0003_00FF);
    // Each source: blocked while its own bit is off, passes when set.
    for (int b = 1; b < 18; b++) begin
      if (EV_BITS[b]) begin
        apb(1'b1, EN, 32'h1 | (EV_BITS & ~(32'h1 << b)));
        fire(32'h1 << b);
        check("irq_blocked", {31'h0, irq_q}, 32'h0);
        apb(1'b0, FL, 32'h0);
        check("flag_set", rd, 32'h1 << b);
        apb(1'b1, EN, 32'h1 | (32'h1 << b));
        irq_is("irq_pass", 1'b1);
        apb(1'b1, FL, 32'h1 << b);
        irq_is("irq_cleared", 1'b0);
      end
    end
    // Global enable off: all sources armed, yet nothing reaches the host.
    apb(1'b1, EN, 32'h0003_7CFE);
    fire(32'hFFFF_FFFF);
    check("irq_global_off", {31'h0, irq_q}, 32'h0);
    apb(1'b0, FL, 32'h0);
    check("flags_all", rd, 32'h0003_7CFE);
    apb(1'b1, FL, 32'h0);
    apb(1'b0, FL, 32'h0);
    check("w0_keeps", rd, 32'h0003_7CFE);
    apb(1'b1, EN, 32'h0003_7CFF);
    irq_is("irq_global_on", 1'b1);
    apb(1'b1, FL, 32'h0003_7CFE);
    apb(1'b0, FL, 32'h0);
    check("flags_clear", rd, 32'h0000_0000);
    irq_is("irq_all_clear", 1'b0);
    // A reset in mid-run returns both words and the output to zero.
    apb(1'b1, EN, 32'h0003_7CFF);
    fire(32'h0000_0002);
    check("irq_before_reset", {31'h0, irq_q}, 32'h1);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, EN, 32'h0);
    check("enable_reset2", rd, 32'h0000_0000);
    apb(1'b0, FL, 32'h0);
    check("flags_reset2", rd, 32'h0000_0000);
    check("irq_reset2", {31'h0, irq_q}, 32'h0);
    give_verdict();
  end
endmodule // vpi_irq_enable_test

`default_nettype wire
